//--- rtl/adc_link_pkg.sv
// constants shared by the sample-and-command link block of a three-channel converter
// assumes one 50 MHz clock; serial link pins are sampled by that clock
package adc_link_pkg;

  // clock and pin timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int READY_PULSE_NS = 40;
  localparam int NARROW_GAP_NS = 20;
  localparam logic [7:0] READY_PULSE_CYC = 8'((READY_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] NARROW_GAP_CYC = 8'((NARROW_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // command words and fixed answers
  localparam logic [15:0] CMD_NOOP = 16'h0000;
  localparam logic [15:0] CMD_RESET = 16'h0011;
  localparam logic [15:0] CMD_STANDBY = 16'h0022;
  localparam logic [15:0] CMD_WAKEUP = 16'h0033;
  localparam logic [15:0] CMD_LOCK = 16'h0555;
  localparam logic [15:0] CMD_UNLOCK_TABLE = 16'h0655;
  localparam logic [15:0] CMD_UNLOCK_HEAD = 16'h0666;
  localparam logic [15:0] RESP_RESET_OK = 16'hFF23;
  localparam logic [2:0] PFX_READ = 3'h5;
  localparam logic [2:0] PFX_WRITE = 3'h3;
  localparam logic [2:0] PFX_READ_HDR = 3'h7;
  localparam logic [2:0] PFX_WRITE_ACK = 3'h2;

  // register space
  localparam int REG_COUNT = 8;
  localparam int REG_IDX_W = 3;
  localparam logic [5:0] ADDR_ID = 6'h00;
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_MODE = 6'h02;
  localparam logic [5:0] ADDR_LIMIT = 6'h08;
  localparam logic [15:0] MODE_DEFAULT = 16'h0510;
  localparam int MODE_FMT_BIT = 0;
  localparam int MODE_RESET_BIT = 10;
  localparam int WLEN_LSB = 8;
  localparam int STAT_LOCK_BIT = 15;

  // word length codes
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_24 = 2'h1;
  localparam logic [1:0] WLEN_32Z = 2'h2;
  localparam logic [1:0] WLEN_32S = 2'h3;

  // conversion coding and frame layout
  localparam logic [23:0] CODE_POS_FS = 24'h7FFFFF;
  localparam logic [23:0] CODE_NEG_FS = 24'h800000;
  localparam logic [7:0] FRAME_WORDS = 8'h05;
  localparam logic [1:0] FIFO_DEPTH = 2'h2;

  // bus side
  localparam logic [3:0] AV_STATE_INDEX = 4'h8;

  typedef enum logic {LINK_IDLE, LINK_SHIFT} link_state_t;

endpackage

//--- rtl/adc_link.sv
// serial command interpreter and conversion-data output path of a three-channel converter
// assumes: link pins come from the host, samples arrive as clk-domain pulses, bus is Avalon-MM
// Notes on behaviour
// - clip to 7FFFFF and 800000 beyond full scale
// - results are 24-bit two's complement codes
// - two-sample buffer per channel
// - channel ready flag holds until both read
// - consecutive reads release one buffered sample each read
// - sync strobe clears all sample buffers
// - level format gives narrow high gap
// - answer goes out in following frame
// - unknown commands act as no-op
// - completed reset frame restores defaults, answers FF23
// - incomplete reset frame answers 0011, no reset
// - standby command enters standby, echoes
// - wakeup command leaves standby, echoes
// - lock allows only no-op, read, unlock
// - locked link still delivers conversion data
// - unlock leaves locked state, echoes word
// - read command: 101, address, count minus one
// - single read answers register contents
// - multi read: 111 header then ascending registers
// - write answers 010, address, written minus one
// - 16-bit words MSB aligned, zero padded
// - frame: answer, three data words, all-zero fifth word
// - writes to read-only or unmapped ignored
// - multi-read answer frame carries no data
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module adc_link
  import adc_link_pkg::*;
#(
  parameter int RAW_W = 26,
  parameter logic [15:0] UNLOCK_CMD = CMD_UNLOCK_TABLE,
  parameter logic [15:0] ID_VALUE = 16'h0A5A // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  input wire logic sync_reset_n,
  output logic sample_ready_n,
  output logic standby,
  input wire logic sample_valid,
  input wire logic signed [RAW_W-1:0] raw_ch0,
  input wire logic signed [RAW_W-1:0] raw_ch1,
  input wire logic signed [RAW_W-1:0] raw_ch2,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage read only by the second
  logic [2:0] sclk_s, cs_s, sync_s;
  logic [1:0] din_s;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_s <= 3'h0;
      cs_s <= 3'h7;
      sync_s <= 3'h7;
      din_s <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s <= {cs_s[1:0], cs_n};
      sync_s <= {sync_s[1:0], sync_reset_n};
      din_s <= {din_s[0], din};
    end
  end
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, sync_fall;
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign cs_fall = ~cs_s[1] & cs_s[2];
  assign cs_rise = cs_s[1] & ~cs_s[2];
  assign sync_fall = ~sync_s[1] & sync_s[2];

  ////////////////////////////////////////////////////////////////////////////
  // state of link, registers and sample buffers
  link_state_t state, next_state;
  logic [5:0] bit_q, next_bit;
  logic [7:0] word_q, next_word;
  logic [31:0] rx_q, next_rx;
  logic [15:0] cmd_q, next_cmd;
  logic dout_q, next_dout;
  logic [1:0] wl_q, next_wl;
  logic [23:0] fdata [3];
  logic [23:0] next_fdata [3];
  logic [15:0] resp_q, next_resp;
  logic multi_q, next_multi;
  logic [5:0] raddr_q, next_raddr;
  logic [6:0] rcnt_q, next_rcnt;
  logic [6:0] wr_cnt, next_wr_cnt;
  logic [15:0] regs [REG_COUNT];
  logic [15:0] next_regs [REG_COUNT];
  logic lock_q, next_lock;
  logic standby_q, next_standby;
  logic [23:0] fifo_mem [3][2];
  logic [23:0] next_fifo_mem [3][2];
  logic [1:0] fifo_cnt [3];
  logic [1:0] next_fifo_cnt [3];
  logic push_evt, pop_evt, data_left, av_we, frame_end, complete;
  logic [15:0] status_w;
  logic signed [RAW_W-1:0] raw [3];
  assign raw[0] = raw_ch0;
  assign raw[1] = raw_ch1;
  assign raw[2] = raw_ch2;
  assign av_we = avs_write & ~avs_waitrequest;
  assign frame_end = (state == LINK_SHIFT) && cs_rise;
  assign complete = word_q >= FRAME_WORDS;
  assign push_evt = sample_valid & ~standby_q;

  // ready flags stay up while any sample is buffered
  assign status_w = {lock_q, 4'h0, regs[ADDR_MODE[REG_IDX_W-1:0]][MODE_RESET_BIT],
                     regs[ADDR_MODE[REG_IDX_W-1:0]][WLEN_LSB +: 2], 5'h00,
                     fifo_cnt[2] != 2'h0, fifo_cnt[1] != 2'h0, fifo_cnt[0] != 2'h0};

  function automatic logic [23:0] clip24(input logic signed [RAW_W-1:0] v);
    if (v > $signed({{(RAW_W-24){1'b0}}, CODE_POS_FS})) clip24 = CODE_POS_FS;
    else if (v < $signed({{(RAW_W-24){1'b1}}, CODE_NEG_FS})) clip24 = CODE_NEG_FS;
    else clip24 = v[23:0];
  endfunction

  function automatic logic [5:0] wl_bits(input logic [1:0] c);
    case (c)
      WLEN_16: wl_bits = 6'd16;
      WLEN_24: wl_bits = 6'd24;
      default: wl_bits = 6'd32;
    endcase
  endfunction

  function automatic logic [15:0] reg_value(input logic [5:0] a);
    if (a == ADDR_ID) reg_value = ID_VALUE;
    else if (a == ADDR_STATUS) reg_value = status_w;
    else if (a < ADDR_LIMIT) reg_value = regs[a[REG_IDX_W-1:0]];
    else reg_value = 16'h0000;
  endfunction

  function automatic logic [15:0] reg_default(input int i);
    reg_default = (i == int'(ADDR_MODE)) ? MODE_DEFAULT : 16'h0000;
  endfunction

  // word k of the outgoing frame, MSB aligned in 32 bits, except WLEN_32S data, which is sign-extended from bit 23
  function automatic logic [31:0] tx_word(input logic [7:0] k);
    logic [23:0] d;
    d = 24'h000000;
    tx_word = 32'h00000000;
    if (multi_q) begin
      if (k == 8'h00) tx_word = {resp_q, 16'h0000};
      else if (k <= {1'b0, rcnt_q} + 8'h01)
        tx_word = {reg_value(raddr_q + 6'(k - 8'h01)), 16'h0000};
    end else if (k == 8'h00) begin
      tx_word = {resp_q, 16'h0000};
    end else if (k <= 8'h03) begin
      d = fdata[2'(k - 8'h01)];
      case (wl_q)
        WLEN_16: tx_word = {d[23:8], 16'h0000};
        WLEN_32S: tx_word = {{8{d[23]}}, d};
        default: tx_word = {d, 8'h00};
      endcase
    end
  endfunction

  // next values for link, command decode, registers and buffers
  always_comb begin
    logic [31:0] rxn;
    logic [31:0] txw;
    logic [15:0] wv;
    logic [5:0] wa;
    rxn = 32'h0;
    txw = 32'h0;
    wv = 16'h0;
    wa = 6'h0;
    next_state = state;
    next_bit = bit_q;
    next_word = word_q;
    next_rx = rx_q;
    next_cmd = cmd_q;
    next_dout = dout_q;
    next_wl = wl_q;
    next_fdata = fdata;
    next_resp = resp_q;
    next_multi = multi_q;
    next_raddr = raddr_q;
    next_rcnt = rcnt_q;
    next_wr_cnt = wr_cnt;
    next_regs = regs;
    next_lock = lock_q;
    next_standby = standby_q;
    next_fifo_mem = fifo_mem;
    next_fifo_cnt = fifo_cnt;
    pop_evt = 1'b0;
    // bus writes land only in writable slots
    if (av_we && avs_address >= 4'(ADDR_MODE) && avs_address < 4'(ADDR_LIMIT))
      next_regs[avs_address[REG_IDX_W-1:0]] = avs_writedata[15:0];
    case (state)
      LINK_IDLE: begin
        next_dout = 1'b0;
        if (cs_fall) begin
          next_state = LINK_SHIFT;
          next_bit = 6'h0;
          next_word = 8'h00;
          next_rx = 32'h0;
          next_cmd = CMD_NOOP;
          next_wr_cnt = 7'h00;
          next_wl = regs[ADDR_MODE[REG_IDX_W-1:0]][WLEN_LSB +: 2];
          for (int i = 0; i < 3; i++) next_fdata[i] = fifo_mem[i][0];
        end
      end
      LINK_SHIFT: begin
        // a function result cannot be bit-selected directly, so hold the word first
        if (sclk_rise) begin
          txw = tx_word(word_q);
          next_dout = txw[5'(6'd31 - bit_q)];
        end
        if (sclk_fall) begin
          rxn = {rx_q[30:0], din_s[1]};
          next_rx = rxn;
          next_bit = bit_q + 6'h01;
          if (bit_q == wl_bits(wl_q) - 6'h01) begin
            wv = 16'(rxn >> (wl_bits(wl_q) - 6'd16));
            next_bit = 6'h0;
            if (word_q != 8'hFF) next_word = word_q + 8'h01;
            if (word_q == 8'h00) next_cmd = wv;
            else if (cmd_q[15:13] == PFX_WRITE && !lock_q && word_q <= {1'b0, cmd_q[6:0]} + 8'h01) begin
              wa = cmd_q[12:7] + 6'(word_q - 8'h01);
              if (wa >= ADDR_MODE && wa < ADDR_LIMIT) begin
                next_regs[wa[REG_IDX_W-1:0]] = wv;
                next_wr_cnt = wr_cnt + 7'h01;
              end
            end
          end
        end
        if (frame_end) begin
          next_state = LINK_IDLE;
          next_dout = 1'b0;
          next_multi = 1'b0;
          next_resp = status_w;
          // data words fully shifted out release their samples
          if (!multi_q) begin
            for (int i = 0; i < 3; i++) begin
              if (word_q > 8'(i + 1) && fifo_cnt[i] != 2'h0) begin
                next_fifo_mem[i][0] = fifo_mem[i][1];
                next_fifo_cnt[i] = fifo_cnt[i] - 2'h1;
                pop_evt = 1'b1;
              end
            end
          end
          if (word_q == 8'h00) begin
            next_resp = status_w;
          end else if (cmd_q[15:13] == PFX_READ) begin
            if (cmd_q[6:0] == 7'h00) begin
              next_resp = reg_value(cmd_q[12:7]);
            end else begin
              next_resp = {PFX_READ_HDR, cmd_q[12:0]};
              next_multi = 1'b1;
              next_raddr = cmd_q[12:7];
              next_rcnt = cmd_q[6:0];
            end
          end else if (cmd_q == UNLOCK_CMD) begin
            next_lock = 1'b0;
            next_resp = cmd_q;
          end else if (!lock_q) begin
            case (cmd_q)
              CMD_RESET: begin
                if (complete) begin
                  for (int i = 0; i < REG_COUNT; i++) next_regs[i] = reg_default(i);
                  for (int i = 0; i < 3; i++) next_fifo_cnt[i] = 2'h0;
                  next_standby = 1'b0;
                  next_resp = RESP_RESET_OK;
                end else begin
                  next_resp = CMD_RESET;
                end
              end
              CMD_STANDBY: begin
                next_standby = 1'b1;
                next_resp = cmd_q;
              end
              CMD_WAKEUP: begin
                next_standby = 1'b0;
                next_resp = cmd_q;
              end
              CMD_LOCK: begin
                next_lock = 1'b1;
                next_resp = cmd_q;
              end
              default: begin
                if (cmd_q[15:13] == PFX_WRITE)
                  next_resp = {PFX_WRITE_ACK, cmd_q[12:7], next_wr_cnt - 7'h01};
                else
                  next_resp = status_w;
              end
            endcase
          end
        end
      end
      default: next_state = LINK_IDLE;
    endcase
    // new sample: fill the two slots, oldest dropped when both are taken
    if (push_evt) begin
      for (int i = 0; i < 3; i++) begin
        if (next_fifo_cnt[i] < FIFO_DEPTH) begin
          next_fifo_mem[i][next_fifo_cnt[i][0]] = clip24(raw[i]);
          next_fifo_cnt[i] = next_fifo_cnt[i] + 2'h1;
        end else begin
          next_fifo_mem[i][0] = next_fifo_mem[i][1];
          next_fifo_mem[i][1] = clip24(raw[i]);
        end
      end
    end
    // the strobe wins over any push in the same cycle
    if (sync_fall) begin
      for (int i = 0; i < 3; i++) next_fifo_cnt[i] = 2'h0;
    end
    data_left = (next_fifo_cnt[0] | next_fifo_cnt[1] | next_fifo_cnt[2]) != 2'h0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= LINK_IDLE;
      bit_q <= 6'h0;
      word_q <= 8'h00;
      rx_q <= 32'h0;
      cmd_q <= CMD_NOOP;
      dout_q <= 1'b0;
      wl_q <= WLEN_24;
      resp_q <= 16'h0000;
      multi_q <= 1'b0;
      raddr_q <= 6'h0;
      rcnt_q <= 7'h00;
      wr_cnt <= 7'h00;
      lock_q <= 1'b0;
      standby_q <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) regs[i] <= reg_default(i);
      for (int i = 0; i < 3; i++) begin
        fdata[i] <= 24'h000000;
        fifo_cnt[i] <= 2'h0;
        fifo_mem[i][0] <= 24'h000000;
        fifo_mem[i][1] <= 24'h000000;
      end
    end else begin
      state <= next_state;
      bit_q <= next_bit;
      word_q <= next_word;
      rx_q <= next_rx;
      cmd_q <= next_cmd;
      dout_q <= next_dout;
      wl_q <= next_wl;
      resp_q <= next_resp;
      multi_q <= next_multi;
      raddr_q <= next_raddr;
      rcnt_q <= next_rcnt;
      wr_cnt <= next_wr_cnt;
      lock_q <= next_lock;
      standby_q <= next_standby;
      regs <= next_regs;
      fdata <= next_fdata;
      fifo_cnt <= next_fifo_cnt;
      fifo_mem <= next_fifo_mem;
    end
  end
  assign dout = dout_q;
  assign standby = standby_q;

  ////////////////////////////////////////////////////////////////////////////
  // ready pin: one timer toggles the pin back after a pulse or a gap
  logic ready_n_q, next_ready_n;
  logic [7:0] rdy_t, next_rdy_t;
  logic fmt_pulse;
  assign fmt_pulse = regs[ADDR_MODE[REG_IDX_W-1:0]][MODE_FMT_BIT];
  always_comb begin
    next_ready_n = ready_n_q;
    next_rdy_t = rdy_t;
    if (push_evt) begin
      next_ready_n = 1'b0;
      next_rdy_t = fmt_pulse ? READY_PULSE_CYC : 8'h00;
    end else if (pop_evt && !fmt_pulse) begin
      // samples left behind show as a gap too narrow to trust
      next_ready_n = 1'b1;
      next_rdy_t = data_left ? NARROW_GAP_CYC : 8'h00;
    end else if (rdy_t != 8'h00) begin
      next_rdy_t = rdy_t - 8'h01;
      if (rdy_t == 8'h01) next_ready_n = ~ready_n_q;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ready_n_q <= 1'b1;
      rdy_t <= 8'h00;
    end else begin
      ready_n_q <= next_ready_n;
      rdy_t <= next_rdy_t;
    end
  end
  assign sample_ready_n = ready_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the answer at the edge waitrequest is low
  logic wait_q, next_wait;
  logic [31:0] rdata_q, next_rdata;
  always_comb begin
    next_wait = 1'b1;
    next_rdata = rdata_q;
    if ((avs_read || avs_write) && wait_q) begin
      next_wait = 1'b0;
      if (avs_address == AV_STATE_INDEX)
        next_rdata = {24'h000000, fifo_cnt[2], fifo_cnt[1], fifo_cnt[0], lock_q, standby_q};
      else if (avs_address < 4'(ADDR_LIMIT))
        next_rdata = {16'h0000, reg_value({2'h0, avs_address})};
      else
        next_rdata = 32'h00000000;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= next_wait;
      rdata_q <= next_rdata;
    end
  end
  assign avs_waitrequest = wait_q;
  assign avs_readdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_clip_top: assert property (push_evt && fifo_cnt[0] == 2'h0 && !sync_fall && !frame_end &&
    raw_ch0 > $signed({{(RAW_W-24){1'b0}}, CODE_POS_FS}) |=> fifo_mem[0][0] == CODE_POS_FS)
    else $error("positive overrange not clipped");
  a_clip_bottom: assert property (push_evt && fifo_cnt[1] == 2'h0 && !sync_fall && !frame_end &&
    raw_ch1 < $signed({{(RAW_W-24){1'b1}}, CODE_NEG_FS}) |=> fifo_mem[1][0] == CODE_NEG_FS)
    else $error("negative overrange not clipped");
  a_code_pass: assert property (push_evt && fifo_cnt[2] == 2'h0 && !sync_fall && !frame_end &&
    raw_ch2 == $signed({{(RAW_W-24){1'b1}}, 24'hFFFFFF}) |=> fifo_mem[2][0] == 24'hFFFFFF)
    else $error("minus one code wrong");
  a_fifo_bound: assert property (fifo_cnt[0] <= FIFO_DEPTH && fifo_cnt[2] <= FIFO_DEPTH)
    else $error("sample buffer over depth");
  a_flag_holds: assert property (fifo_cnt[0] == 2'h2 && !sync_fall && frame_end |=>
    status_w[0] ##1 (status_w[0] || push_evt || $past(sync_fall)))
    else $error("ready flag dropped after one read");
  a_sync_clear: assert property (sync_fall |=> fifo_cnt[0] == 2'h0 && fifo_cnt[1] == 2'h0
    && fifo_cnt[2] == 2'h0 && status_w[2:0] == 3'h0)
    else $error("strobe left samples buffered");
  a_reset_done: assert property (frame_end && complete && cmd_q == CMD_RESET && !lock_q |=>
    resp_q == RESP_RESET_OK && regs[ADDR_MODE[REG_IDX_W-1:0]] == MODE_DEFAULT)
    else $error("reset frame not honoured");
  a_reset_short: assert property (frame_end && !complete && word_q != 8'h00 && !av_we &&
    cmd_q == CMD_RESET && !lock_q |=> resp_q == CMD_RESET && $stable(regs[ADDR_MODE[REG_IDX_W-1:0]]))
    else $error("short reset frame acted");
  a_lock_guard: assert property (lock_q && frame_end && (cmd_q == CMD_STANDBY || cmd_q == CMD_WAKEUP)
    |=> $stable(standby_q) && lock_q && resp_q == $past(status_w))
    else $error("locked link acted on command");
  a_multi_head: assert property (frame_end && word_q != 8'h00 && cmd_q[15:13] == PFX_READ &&
    cmd_q[6:0] != 7'h00 |=> multi_q && resp_q == {PFX_READ_HDR, $past(cmd_q[12:0])})
    else $error("multi read header wrong");
  a_first_bit: assert property (state == LINK_SHIFT && sclk_rise && !cs_rise && word_q == 8'h00 &&
    bit_q == 6'h0 |=> dout == resp_q[15])
    else $error("answer not leading the frame");
  c_reset_frame: cover property (frame_end && complete && cmd_q == CMD_RESET);
  c_multi_read: cover property (frame_end && cmd_q[15:13] == PFX_READ && cmd_q[6:0] != 7'h00);
  c_sync_full: cover property (sync_fall && fifo_cnt[0] == 2'h2);
  c_narrow_gap: cover property (pop_evt && data_left && !fmt_pulse);

endmodule // adc_link

//--- tb/spi_host.sv
// host-side link master model: clocks frames out on din and collects dout words
// assumes the device samples din on sclk fall and moves dout a few clocks after sclk rises
`timescale 1ns/1ps
module spi_host (
  output logic sclk,
  output logic cs_n,
  output logic din,
  input wire logic dout
);
  logic [23:0] rx [0:7];
  // sclk stands low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // dout is taken just before the next rise, long after it has settled
  task automatic frame(input logic [23:0] w0, input logic [23:0] w1, input int n);
    cs_n <= 1'b0;
    #213;
    for (int k = 0; k < n; k++) begin
      for (int b = 23; b >= 0; b--) begin
        din = (k == 0) ? w0[b] : (k == 1) ? w1[b] : 1'b0;
        sclk = 1'b1;
        #80;
        sclk = 1'b0;
        #80;
        rx[k][b] = dout;
      end
    end
    #207;
    cs_n <= 1'b1;
    #1000;
  endtask
endmodule // spi_host

//--- tb/adc_link_tb.sv
// self-checking bench: coding table, sample buffers, link commands, register bus
// assumes the host model drives the link; this bench drives samples, sync pin and bus
`timescale 1ns/1ps
module adc_link_tb;
  import adc_link_pkg::*;
  localparam logic [15:0] ID_CODE = 16'h0C3C; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, din, dout, sample_ready_n, standby, avs_waitrequest;
  logic sync_reset_n = 1'b1;
  logic sample_valid = 1'b0;
  logic signed [25:0] raw = '0;
  logic [3:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rd;
  logic [23:0] rx [0:7];
  int errors = 0;
  int total_checks = 0;
  logic signed [25:0] raw_tab [7] = '{26'sh0, 26'sh1, -26'sh1, 26'sh7FFFFF, 26'sh800005,
    -26'sh800000, -26'sh800009};
  logic [23:0] exp_tab [7] = '{24'h000000, 24'h000001, 24'hFFFFFF, 24'h7FFFFF, 24'h7FFFFF,
    24'h800000, 24'h800000};

  always #10 clk = ~clk;

  adc_link #(.ID_VALUE(ID_CODE)) u_adc_link (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
    .din(din), .dout(dout), .sync_reset_n(sync_reset_n), .sample_ready_n(sample_ready_n),
    .standby(standby), .sample_valid(sample_valid), .raw_ch0(raw), .raw_ch1(raw),
    .raw_ch2(raw), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  spi_host u_spi_host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

  ////////////////////////////////////////////////////////////////////////////////////////////
  // compares: link words and pins, then bus words
  task automatic chk_l(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_a(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low; read data taken at that edge only
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= wd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic push(input logic signed [25:0] r);
    @(posedge clk);
    raw <= r;
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic f(input logic [15:0] c, input logic [15:0] w, input int n);
    u_spi_host.frame({c, 8'h00}, {w, 8'h00}, n);
    rx = u_spi_host.rx;
  endtask
  task automatic print_verdict;
    if (errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // a hung handshake would otherwise stall the run forever
  initial begin
    #1500000;
    errors++;
    print_verdict;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    // table rows: one sample per frame, read at once
    for (int i = 0; i < 7; i++) begin
      push(raw_tab[i]);
      chk_l({23'h0, sample_ready_n}, 24'h0);
      f(CMD_NOOP, 16'h0, 5);
      chk_l(rx[1], exp_tab[i]);
      chk_l(rx[3], exp_tab[i]);
      chk_l(rx[4], 24'h0);
      chk_l({23'h0, sample_ready_n}, 24'h1);
    end
    f(16'h1234, 16'h0, 5);
    chk_l(rx[0], 24'h050700);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[0], 24'h050000);
    // overfilled buffer keeps the two newest; flags stay until both are read
    push(26'sh5);
    push(26'sh6);
    push(26'sh7);
    av(1'b0, 4'h8, 32'h0);
    chk_a(rd, 32'h000000A8);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[1], 24'h000006);
    chk_l({23'h0, sample_ready_n}, 24'h0);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[0], 24'h050700);
    chk_l(rx[2], 24'h000007);
    chk_l({23'h0, sample_ready_n}, 24'h1);
    push(26'sh1);
    push(26'sh2);
    @(posedge clk);
    sync_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    sync_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    av(1'b0, 4'h8, 32'h0);
    chk_a(rd, 32'h0);
    // power and lock commands
    f(CMD_STANDBY, 16'h0, 5);
    chk_l({23'h0, standby}, 24'h1);
    f(CMD_WAKEUP, 16'h0, 5);
    chk_l(rx[0], 24'h002200);
    chk_l({23'h0, standby}, 24'h0);
    f(CMD_LOCK, 16'h0, 5);
    chk_l(rx[0], 24'h003300);
    push(26'sh3);
    f(CMD_STANDBY, 16'h0, 5);
    chk_l(rx[0], 24'h055500);
    chk_l(rx[1], 24'h000003);
    chk_l({23'h0, standby}, 24'h0);
    av(1'b0, 4'h8, 32'h0);
    chk_a(rd, 32'h2);
    f(CMD_UNLOCK_TABLE, 16'h0, 5);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[0], 24'h065500);
    av(1'b0, 4'h8, 32'h0);
    chk_a(rd, 32'h0);
    // register reads and writes over the link and the bus
    av(1'b1, 4'h3, 32'h1234);
    av(1'b1, 4'h4, 32'h5678);
    f({PFX_READ, 6'h02, 7'h00}, 16'h0, 5);
    f({PFX_READ, 6'h03, 7'h01}, 16'h0, 5);
    chk_l(rx[0], 24'h051000);
    push(26'sh9);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[0], 24'hE18100);
    chk_l(rx[1], 24'h123400);
    chk_l(rx[2], 24'h567800);
    av(1'b0, 4'h8, 32'h0);
    chk_a(rd, 32'h54);
    f({PFX_WRITE, 6'h07, 7'h01}, 16'hBEEF, 5);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[0], 24'h438000);
    av(1'b0, 4'h7, 32'h0);
    chk_a(rd, 32'h0000BEEF);
    av(1'b1, 4'h0, 32'hFFFF);
    av(1'b0, 4'h0, 32'h0);
    chk_a(rd, {16'h0, ID_CODE});
    av(1'b0, 4'hC, 32'h0);
    chk_a(rd, 32'h0);
    // reset command: a one-word frame must not reset, a full frame must
    av(1'b1, 4'h2, 32'h0511);
    f(CMD_RESET, 16'h0, 1);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[0], 24'h001100);
    av(1'b0, 4'h2, 32'h0);
    chk_a(rd, 32'h0511);
    f(CMD_RESET, 16'h0, 5);
    f(CMD_NOOP, 16'h0, 5);
    chk_l(rx[0], 24'hFF2300);
    av(1'b0, 4'h2, 32'h0);
    chk_a(rd, 32'h0510);
    print_verdict;
  end
endmodule // adc_link_tb
